//--- async_serial_port.sv
// Asynchronous serial port, frame modes 1, 2 and 3
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.svh"

module async_serial_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,

  // Configuration
  input wire logic [1:0] mode_i,
  input wire logic mode2_fast_i,
  input wire logic multiprocessor_filter_bit_i,
  input wire logic transmit_ninth_bit_i,
  input wire logic transmit_clock_source_select_i,
  input wire logic receive_clock_source_select_i,

  // Timer overflow pulses, one clock wide
  input wire logic timer1_overflow_i,
  input wire logic timer2_overflow_i,

  // Processor side
  input wire logic buf_wr_i,
  input wire logic [7:0] buf_wdata_i,
  input wire logic transmit_done_clr_i,
  input wire logic receive_done_clr_i,
  output logic [7:0] serial_data_buffer_o,
  output logic received_ninth_bit_o,
  output logic transmit_done_flag_o,
  output logic receive_done_flag_o,
  output logic tx_busy_o,
  output logic rx_busy_o,
  output logic frame_lost_o,

  // Line side
  input wire logic rxd_i,
  output logic txd_o
);

  import serial_port_pkg::*;

  port_state_t state_reg;
  port_state_t state_next;

  logic mode_async;
  logic mode_nine;
  logic mode2_tick;
  logic tx_tick;
  logic rx_tick;
  logic tx_roll;
  logic rx_roll;
  logic rx_bit;
  logic rx_final;
  logic [8:0] rx_shifted;
  logic rx_accept;
  logic tx_set;
  logic rx_set;
  logic tx_load;
  logic tx_at_end;
  logic rx_edge;
  logic rx_false_start;

  // Pick the 16x tick for one direction
  function automatic logic pick_tick(
    input logic [1:0] mode,
    input logic m2_tick,
    input logic use_timer2,
    input logic t1_ovf,
    input logic t2_ovf
  );
    logic tick;
    tick = 1'b0;
    case (mode)
      `MODE_9BIT_FIXED: begin
        tick = m2_tick;
      end
      `MODE_8BIT,
      `MODE_9BIT_VAR: begin
        tick = use_timer2 ? t2_ovf : t1_ovf;
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    return tick;
  endfunction

  // Two of three samples decide the bit
  function automatic logic majority3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Shift right by one, filling the top bit
  function automatic logic [8:0] shift_right(input logic [8:0] v,
                                             input logic fill);
    return {fill, v[8:1]};
  endfunction

  // Mode decode
  assign mode_async = (mode_i != `MODE_SYNC);
  assign mode_nine = (mode_i == `MODE_9BIT_FIXED) ||
                     (mode_i == `MODE_9BIT_VAR);

  // Mode 2 runs the 16x tick at clk/2, or every clock when fast
  assign mode2_tick = mode2_fast_i | state_reg.mode2_phase;

  assign tx_tick = pick_tick(mode_i, mode2_tick,
                             transmit_clock_source_select_i,
                             timer1_overflow_i, timer2_overflow_i);
  assign rx_tick = pick_tick(mode_i, mode2_tick,
                             receive_clock_source_select_i,
                             timer1_overflow_i, timer2_overflow_i);

  // Rollovers of the two divide-by-16 counters
  assign tx_roll = tx_tick && (state_reg.tx_div == `DIV_LAST);
  assign rx_roll = rx_tick && (state_reg.rx_div == `DIV_LAST);

  // Receive bit decision and final-shift detection
  assign rx_bit = majority3(state_reg.rx_votes);
  assign rx_shifted = shift_right(state_reg.rx_shift, rx_bit);
  // Start bit at the far end means this shift takes the last sampled bit of the frame
  assign rx_final = (state_reg.rx_shift[0] == 1'b0);

  // New bit is the stop bit in mode 1, the ninth bit otherwise
  assign rx_accept = !state_reg.rx_done &&
                     (!multiprocessor_filter_bit_i || rx_bit);

  // No double buffer: writes while pending or sending are dropped
  assign tx_load = buf_wr_i && mode_async && !state_reg.tx_req &&
                   (state_reg.tx_state == TX_IDLE);
  // A ninth bit of zero can mimic the marker before the stop is in
  assign tx_at_end = (!mode_nine || state_reg.tx_shifted) &&
                     (state_reg.tx_shift[8:1] == `TX_END_MARK);

  // Falling edge seen at a 16x tick
  assign rx_edge = rx_tick && state_reg.rx_prev &&
                   !state_reg.rx_line;
  // First decision of a frame is the start bit
  assign rx_false_start = (state_reg.rx_shift == `RX_SHIFT_INIT) &&
                          rx_bit;

  always_comb begin
    state_next = state_reg;
    tx_set = 1'b0;
    rx_set = 1'b0;
    state_next.frame_lost = 1'b0;

    // Line synchroniser: a change counts once stages 2 and 3 agree
    // Stage 1 may be metastable, so it never feeds a decision
    state_next.rxd_sync = {state_reg.rxd_sync[1:0], rxd_i};
    if (state_reg.rxd_sync[1] == state_reg.rxd_sync[2]) begin
      state_next.rx_line = state_reg.rxd_sync[2];
    end

    // Mode 2 prescaler
    state_next.mode2_phase = ~state_reg.mode2_phase;

    // Transmit divide-by-16 counter runs free
    if (tx_tick) begin
      state_next.tx_div = state_reg.tx_div + 4'h1;
    end

    // Transmitter
    case (state_reg.tx_state)
      TX_IDLE: begin
        state_next.txd = 1'b1;
        if (tx_load) begin
          state_next.tx_req = 1'b1;
          state_next.tx_shifted = 1'b0;
          if (mode_nine) begin
            state_next.tx_shift = {transmit_ninth_bit_i,
                                   buf_wdata_i};
          end else begin
            state_next.tx_shift = {1'b1, buf_wdata_i};
          end
        end
        // Bit times follow the counter, not the write
        if (state_reg.tx_req && tx_roll) begin
          state_next.tx_req = 1'b0;
          state_next.tx_state = TX_START;
          state_next.txd = 1'b0;
        end
        if (!mode_async) begin
          state_next.tx_req = 1'b0;
        end
      end
      TX_START: begin
        if (tx_roll) begin
          state_next.tx_state = TX_DATA;
          state_next.txd = state_reg.tx_shift[0];
        end
      end
      TX_DATA: begin
        if (tx_roll) begin
          state_next.tx_shifted = 1'b1;
          if (!mode_nine || state_reg.tx_shifted) begin
            state_next.tx_shift = shift_right(state_reg.tx_shift, 1'b0);
          end else begin
            // First shift brings in the stop bit
            state_next.tx_shift = shift_right(state_reg.tx_shift, 1'b1);
          end
          state_next.txd = state_next.tx_shift[0];
          if (tx_at_end) begin
            state_next.tx_state = TX_IDLE;
            state_next.txd = 1'b1;
            tx_set = 1'b1;
          end
        end
      end
      default: begin
        state_next.tx_state = TX_IDLE;
        state_next.txd = 1'b1;
      end
    endcase

    // Leaving the async modes drops any frame in flight
    if (!mode_async) begin
      state_next.tx_state = TX_IDLE;
      state_next.txd = 1'b1;
    end

    // Receive divide-by-16 counter and edge sampling at 16x
    if (rx_tick) begin
      state_next.rx_div = state_reg.rx_div + 4'h1;
      state_next.rx_prev = state_reg.rx_line;
    end

    // Receiver
    case (state_reg.rx_state)
      RX_HUNT: begin
        if (rx_edge) begin
          state_next.rx_div = `DIV_RESET + 4'h1;
          state_next.rx_shift = `RX_SHIFT_INIT;
          state_next.rx_votes = 3'h0;
          state_next.rx_state = RX_BITS;
        end
      end
      RX_BITS: begin
        if (rx_tick) begin
          case (state_reg.rx_div)
            `SAMPLE_FIRST: begin
              state_next.rx_votes[0] = state_reg.rx_line;
            end
            `SAMPLE_MID: begin
              state_next.rx_votes[1] = state_reg.rx_line;
            end
            `SAMPLE_LAST: begin
              state_next.rx_votes[2] = state_reg.rx_line;
            end
            default: begin
              state_next.rx_votes = state_reg.rx_votes;
            end
          endcase
        end
        if (rx_roll) begin
          state_next.rx_shift = rx_shifted;
          if (rx_false_start) begin
            // False start: noise rejected
            state_next.rx_state = RX_HUNT;
            state_next.rx_shift = `RX_SHIFT_INIT;
          end else if (rx_final) begin
            if (rx_accept) begin
              state_next.data_buf = rx_shifted[7:0];
              state_next.rx_ninth = rx_shifted[8];
              rx_set = 1'b1;
            end else begin
              state_next.frame_lost = 1'b1;
            end
            if (mode_nine) begin
              // Stop bit still to come; its value is never used
              state_next.rx_state = RX_TRAIL;
            end else begin
              state_next.rx_state = RX_HUNT;
            end
          end
        end
      end
      RX_TRAIL: begin
        // A low stop bit here must not look like a fresh start edge
        if (rx_roll) begin
          state_next.rx_state = RX_HUNT;
        end
      end
      default: begin
        state_next.rx_state = RX_HUNT;
      end
    endcase

    if (!mode_async) begin
      state_next.rx_state = RX_HUNT;
    end

    // Done flags: a set in the clearing cycle wins
    if (tx_set) begin
      state_next.tx_done = 1'b1;
    end else if (transmit_done_clr_i) begin
      state_next.tx_done = 1'b0;
    end
    if (rx_set) begin
      state_next.rx_done = 1'b1;
    end else if (receive_done_clr_i) begin
      state_next.rx_done = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg.rxd_sync <= `RXD_SYNC_RESET;
      state_reg.rx_line <= 1'b1;
      state_reg.rx_prev <= 1'b1;
      state_reg.mode2_phase <= 1'b0;
      state_reg.tx_div <= `DIV_RESET;
      state_reg.tx_req <= 1'b0;
      state_reg.tx_state <= TX_IDLE;
      state_reg.tx_shift <= `RX_SHIFT_INIT;
      state_reg.tx_shifted <= 1'b0;
      state_reg.txd <= 1'b1;
      state_reg.rx_div <= `DIV_RESET;
      state_reg.rx_state <= RX_HUNT;
      state_reg.rx_shift <= `RX_SHIFT_INIT;
      state_reg.rx_votes <= 3'h0;
      state_reg.data_buf <= `DATA_BUF_RESET;
      state_reg.rx_ninth <= 1'b0;
      state_reg.tx_done <= 1'b0;
      state_reg.rx_done <= 1'b0;
      state_reg.frame_lost <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs, all from flops except the busy decodes
  assign txd_o = state_reg.txd;
  assign serial_data_buffer_o = state_reg.data_buf;
  assign received_ninth_bit_o = state_reg.rx_ninth;
  assign transmit_done_flag_o = state_reg.tx_done;
  assign receive_done_flag_o = state_reg.rx_done;
  assign frame_lost_o = state_reg.frame_lost;
  assign tx_busy_o = state_reg.tx_req || (state_reg.tx_state != TX_IDLE);
  assign rx_busy_o = (state_reg.rx_state != RX_HUNT);

endmodule // async_serial_port

`default_nettype wire

//--- serial_port_regs.svh
// Constants of the asynchronous serial port, frame modes 1 to 3
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// Frame mode codes on the mode input
`define MODE_SYNC 2'h0
`define MODE_8BIT 2'h1
`define MODE_9BIT_FIXED 2'h2
`define MODE_9BIT_VAR 2'h3

// Divide-by-16 counter
`define DIV_LAST 4'hf
`define DIV_RESET 4'h0
`define SAMPLE_FIRST 4'h7
`define SAMPLE_MID 4'h8
`define SAMPLE_LAST 4'h9

// Shift register values
`define RX_SHIFT_INIT 9'h1ff
`define TX_END_MARK 8'h01

// Reset values
`define DATA_BUF_RESET 8'h00
`define RXD_SYNC_RESET 3'h7

`endif

//--- serial_port_pkg.sv
// Types shared by the asynchronous serial port
package serial_port_pkg;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_BITS,
    RX_TRAIL
  } rx_state_t;

  typedef struct packed {
    logic [2:0] rxd_sync;
    logic rx_line;
    logic rx_prev;
    logic mode2_phase;
    logic [3:0] tx_div;
    logic tx_req;
    tx_state_t tx_state;
    logic [8:0] tx_shift;
    logic tx_shifted;
    logic txd;
    logic [3:0] rx_div;
    rx_state_t rx_state;
    logic [8:0] rx_shift;
    logic [2:0] rx_votes;
    logic [7:0] data_buf;
    logic rx_ninth;
    logic tx_done;
    logic rx_done;
    logic frame_lost;
  } port_state_t;

endpackage

//--- async_serial_port_sva.sv
// Port-level assertions for the asynchronous serial port
`timescale 1ns/100ps
`default_nettype none

module async_serial_port_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Inputs watched
  input wire logic [1:0] mode_i,
  input wire logic buf_wr_i,
  input wire logic transmit_done_clr_i,
  // Outputs watched
  input wire logic [7:0] serial_data_buffer_o,
  input wire logic transmit_done_flag_o,
  input wire logic receive_done_flag_o,
  input wire logic tx_busy_o,
  input wire logic rx_busy_o,
  input wire logic frame_lost_o,
  input wire logic txd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_idle_line_high: assert property (!tx_busy_o |-> txd_o)
    else $error("line low while idle");
  a_write_starts_send: assert property (
    buf_wr_i && !tx_busy_o && mode_i != 2'h0 |=> tx_busy_o)
    else $error("buffer write not taken");
  // Every line bit lasts at least eight clocks
  a_line_bit_holds: assert property (
    !$stable(txd_o) |=> $stable(txd_o) [*7])
    else $error("line bit too short");
  a_done_ends_send: assert property (
    $rose(transmit_done_flag_o) |-> !tx_busy_o && txd_o)
    else $error("done flag while sending");
  a_tx_flag_clears: assert property (
    transmit_done_clr_i && !tx_busy_o |=> !transmit_done_flag_o)
    else $error("done flag not cleared");
  a_rx_flag_from_frame: assert property (
    $rose(receive_done_flag_o) |-> $past(rx_busy_o))
    else $error("receive flag without frame");
  a_lost_keeps_data: assert property (
    frame_lost_o |-> $stable(serial_data_buffer_o)
    && !$rose(receive_done_flag_o))
    else $error("refused frame changed results");
  a_buffer_with_flag: assert property (
    !$stable(serial_data_buffer_o) |-> $rose(receive_done_flag_o))
    else $error("buffer changed without flag");
  a_start_bit_span: assert property (
    $rose(rx_busy_o) |=> rx_busy_o [*6])
    else $error("receiver dropped start too early");
  a_lost_one_pulse: assert property (
    frame_lost_o |=> !frame_lost_o)
    else $error("lost pulse too long");
endmodule // async_serial_port_sva

bind async_serial_port async_serial_port_sva chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .mode_i(mode_i), .buf_wr_i(buf_wr_i),
  .transmit_done_clr_i(transmit_done_clr_i),
  .serial_data_buffer_o(serial_data_buffer_o),
  .transmit_done_flag_o(transmit_done_flag_o),
  .receive_done_flag_o(receive_done_flag_o), .tx_busy_o(tx_busy_o),
  .rx_busy_o(rx_busy_o), .frame_lost_o(frame_lost_o), .txd_o(txd_o));
`default_nettype wire

//--- remote_line_model.sv
// Remote serial transceiver model on the line pins
`timescale 1ns/100ps
`default_nettype none

module remote_line_model (
  // Clock
  input wire logic clk_i,
  // Line pins
  input wire logic txd_i,
  output logic rxd_o,
  // Frame shape set by the bench
  input wire logic [5:0] bit_clks_i,
  input wire logic [3:0] frame_bits_i
);
  logic [10:0] frames [$];
  logic [10:0] cap;

  initial rxd_o = 1'b1;

  // Mid-bit sampling; a short frame leaves the top bits high
  always begin
    @(negedge txd_i);
    cap = '1;
    repeat (bit_clks_i / 2) @(posedge clk_i);
    for (int i = 0; i < frame_bits_i; i++) begin
      cap[i] = txd_i;
      repeat (bit_clks_i) @(posedge clk_i);
    end
    frames.push_back(cap);
  end

  // Line returns to idle high after the last bit
  task automatic send_frame(input logic [10:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i];
      repeat (bt) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
endmodule // remote_line_model
`default_nettype wire

//--- async_serial_port_tb_top.sv
// Self-checking bench for the asynchronous serial port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  failures++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end

module async_serial_port_tb_top;
  logic clk_i, sys_rst_i, fast, mpf, tb8, tsel, t1, t2, wr, tclr, rclr, rxd;
  logic rb8, tdone, rdone, tbusy, rbusy, lost, txd, m_flag, m_rb8;
  logic [1:0] mode;
  logic [7:0] wd, rbuf, m_buf;
  logic [5:0] bt;
  logic [3:0] nb;
  int failures = 0;
  int checks_done = 0;
  int lost_seen = 0;
  int lost_exp = 0;

  async_serial_port uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode),
    .mode2_fast_i(fast), .multiprocessor_filter_bit_i(mpf),
    .transmit_ninth_bit_i(tb8), .transmit_clock_source_select_i(tsel),
    .receive_clock_source_select_i(tsel), .timer1_overflow_i(t1),
    .timer2_overflow_i(t2), .buf_wr_i(wr), .buf_wdata_i(wd),
    .transmit_done_clr_i(tclr), .receive_done_clr_i(rclr),
    .serial_data_buffer_o(rbuf), .received_ninth_bit_o(rb8),
    .transmit_done_flag_o(tdone), .receive_done_flag_o(rdone),
    .tx_busy_o(tbusy), .rx_busy_o(rbusy), .frame_lost_o(lost), .rxd_i(rxd),
    .txd_o(txd));
  remote_line_model partner (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd),
    .bit_clks_i(bt), .frame_bits_i(nb));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Timer 1 ticks every second clock, timer 2 every clock
  always @(posedge clk_i) t1 <= ~t1;
  always @(posedge clk_i) if (lost === 1'b1) lost_seen++;

  task automatic cfg(input logic [1:0] m, input logic s);
    mode <= m;
    tsel <= s;
    fast <= s;
    bt = s ? 6'd16 : 6'd32;
    nb = (m == 2'h1) ? 4'd10 : 4'd11;
    @(posedge clk_i);
  endtask

  task automatic tx_case(input logic [1:0] m, input logic s);
    logic [10:0] ex;
    int n;
    cfg(m, s);
    wd <= 8'($urandom);
    tb8 <= 1'($urandom);
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    ex = (m == 2'h1) ? {2'b11, wd, 1'b0} : {1'b1, tb8, wd, 1'b0};
    n = 0;
    while (tdone !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("done time", 1'b1, n >= (nb-1)*bt && n <= nb*bt+2)
    repeat (2 * bt) @(posedge clk_i);
    `CHK("tx frame", ex, partner.frames.pop_front())
    tclr <= 1'b1;
    @(posedge clk_i);
    tclr <= 1'b0;
  endtask

  task automatic rx_case(input logic [1:0] m, input logic s, input logic b9,
                         input logic stp, input logic f, input logic clr);
    logic [7:0] d;
    logic bit9;
    int n;
    cfg(m, s);
    mpf <= f;
    d = 8'($urandom);
    bit9 = (m == 2'h1) ? stp : b9;
    partner.send_frame({stp | (m == 2'h1), bit9, d, 1'b0}, nb, bt);
    n = 0;
    while (rbusy !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    if (!m_flag && (!f || bit9)) begin
      m_flag = 1'b1;
      m_buf = d;
      m_rb8 = bit9;
    end else lost_exp++;
    `CHK("rx flag", m_flag, rdone)
    `CHK("rx data", m_buf, rbuf)
    `CHK("ninth bit", m_rb8, rb8)
    if (clr) begin
      rclr <= 1'b1;
      m_flag = 1'b0;
      @(posedge clk_i);
      rclr <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {sys_rst_i, t1, t2, m_flag, m_rb8, m_buf, bt, nb} = '1;
    {fast, mpf, tb8, tsel, wr, tclr, rclr, wd, mode} = '0;
    {m_flag, m_rb8, m_buf} = '0;
    void'($urandom(8867));
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("idle line", 1'b1, txd)
    `CHK("idle flags", 3'b000, {tdone, rdone, tbusy})
    `CHK("reset buffer", 8'h00, rbuf)
    for (int m = 1; m < 4; m++)
      for (int s = 0; s < 2; s++)
        tx_case(m[1:0], s[0]);
    rx_case(2'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    rx_case(2'h2, 1'b1, 1'($urandom), 1'b1, 1'b0, 1'b0);
    rx_case(2'h3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    rx_case(2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    rx_case(2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    rx_case(2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    cfg(2'h1, 1'b0);
    partner.send_frame(11'h000, 1, 6);
    repeat (64) @(posedge clk_i);
    `CHK("false start", {1'b0, m_flag}, {rbusy, rdone})
    rx_case(2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    `CHK("lost count", lost_exp, lost_seen)
    cfg(2'h0, 1'b0);
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("sync mode idle", 2'b01, {tbusy, txd})
    finish_test;
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    finish_test;
  end
endmodule // async_serial_port_tb_top
`default_nettype wire
